// ===== pkg/tmrif_pkg.sv
// Register map, field positions and mode encodings for the timer flag/counter block
package tmrif_pkg;
  // I/O register addresses (6-bit I/O space)
  localparam logic [5:0] TMRIF_ADDR_MASK   = 6'h26;
  localparam logic [5:0] TMRIF_ADDR_FLAGS  = 6'h25;
  localparam logic [5:0] TMRIF_ADDR_T0CMPA = 6'h20;
  localparam logic [5:0] TMRIF_ADDR_T0CMPB = 6'h21;
  localparam logic [5:0] TMRIF_ADDR_T1CTL  = 6'h22;
  localparam logic [5:0] TMRIF_ADDR_T1CNTL = 6'h23;
  localparam logic [5:0] TMRIF_ADDR_T1CNTH = 6'h24;
  localparam logic [5:0] TMRIF_ADDR_T1CMPA = 6'h1e;
  localparam logic [5:0] TMRIF_ADDR_T1CMPB = 6'h1f;
  localparam logic [5:0] TMRIF_ADDR_T0CNT  = 6'h1d;
  localparam logic [5:0] TMRIF_ADDR_T0MODE = 6'h1c;

  // Mask and flag bit positions (shared layout)
  localparam int TMRIF_B_T0_OVF  = 0;
  localparam int TMRIF_B_T0_CMPA = 1;
  localparam int TMRIF_B_T0_CMPB = 2;
  localparam int TMRIF_B_T1_OVF  = 3;
  localparam int TMRIF_B_T1_CMPA = 4;
  localparam int TMRIF_B_T1_CMPB = 5;
  localparam int TMRIF_B_RSVD    = 6;
  localparam int TMRIF_B_T1_CAPT = 7;
  localparam logic [7:0] TMRIF_RSVD_MASK = 8'hbf;

  // Timer1 control layout: [2:0] clock select, [3] match-clear, [4] 16-bit width
  localparam int TMRIF_T1_CS_LSB = 0;
  localparam int TMRIF_T1_MCLR   = 3;
  localparam int TMRIF_T1_WIDE   = 4;

  localparam logic [7:0]  TMRIF_BOTTOM  = 8'h00;
  localparam logic [7:0]  TMRIF_MAX     = 8'hff;
  localparam logic [15:0] TMRIF_MAX16   = 16'hffff;
  localparam logic [7:0]  TMRIF_RESET8  = 8'h00;
  localparam logic [2:0]  TMRIF_CS_STOP = 3'h0;

  // Timer0 waveform modes
  typedef enum logic [2:0] {
    TMRIF_WM_NORMAL  = 3'b000,
    TMRIF_WM_PC_FIX  = 3'b001,
    TMRIF_WM_CTC     = 3'b010,
    TMRIF_WM_FP_FIX  = 3'b011,
    TMRIF_WM_RSV4    = 3'b100,
    TMRIF_WM_PC_REG  = 3'b101,
    TMRIF_WM_RSV6    = 3'b110,
    TMRIF_WM_FP_REG  = 3'b111
  } tmrif_wmode_t;
endpackage : tmrif_pkg

// ===== hw/tmrif_core.sv
// Timer interrupt mask/flag registers and the 8/16-bit Timer1 counter unit
module tmrif_core
  import tmrif_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // CPU I/O register bus
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // CPU interrupt side
  input  wire logic       global_irq_en,
  input  wire logic [7:0] vector_ack,
  output logic      [7:0] irq_req,
  // Timer0 side (count tick comes in, counter is kept here)
  input  wire logic       t0_tick,
  output logic            t0_wave_out_b,
  // Timer1 clock sources and capture event
  input  wire logic [2:0] t1_tick_sources,
  input  wire logic       t1_ext_pin,
  input  wire logic       t1_capture_evt
);

  // Register state
  logic [7:0] mask_r, flags_r, flags_nxt;
  logic [7:0] t0_cmpa_r, t0_cmpb_r, t0_cnt_r, t0_cnt_nxt;
  logic [2:0] t0_mode_r;
  logic       t0_down_r, t0_down_nxt;
  logic [7:0] t1_ctl_r, t1_cmpa_r, t1_cmpb_r;
  logic [7:0] t1_lo_r, t1_hi_r, t1_lo_nxt, t1_hi_nxt;
  logic [7:0] t1_tmp_r;
  logic       t1_blk_r;
  logic       wave_b_r;
  logic [2:0] ext_sync_r;
  logic       ext_prev_r;

  // Address decode
  wire wr_mask   = io_wr && (io_addr == TMRIF_ADDR_MASK);
  wire wr_flags  = io_wr && (io_addr == TMRIF_ADDR_FLAGS);
  wire wr_t0cmpa = io_wr && (io_addr == TMRIF_ADDR_T0CMPA);
  wire wr_t0cmpb = io_wr && (io_addr == TMRIF_ADDR_T0CMPB);
  wire wr_t0cnt  = io_wr && (io_addr == TMRIF_ADDR_T0CNT);
  wire wr_t0mode = io_wr && (io_addr == TMRIF_ADDR_T0MODE);
  wire wr_t1ctl  = io_wr && (io_addr == TMRIF_ADDR_T1CTL);
  wire wr_t1lo   = io_wr && (io_addr == TMRIF_ADDR_T1CNTL);
  wire wr_t1hi   = io_wr && (io_addr == TMRIF_ADDR_T1CNTH);
  wire wr_t1cmpa = io_wr && (io_addr == TMRIF_ADDR_T1CMPA);
  wire wr_t1cmpb = io_wr && (io_addr == TMRIF_ADDR_T1CMPB);
  wire rd_t1lo   = io_rd && (io_addr == TMRIF_ADDR_T1CNTL);

  // Timer0 compare and overflow
  tmrif_wmode_t t0_mode;
  assign t0_mode = tmrif_wmode_t'(t0_mode_r);
  wire t0_phase  = (t0_mode == TMRIF_WM_PC_FIX) || (t0_mode == TMRIF_WM_PC_REG);
  wire t0_regtop = (t0_mode == TMRIF_WM_PC_REG) || (t0_mode == TMRIF_WM_FP_REG)
                   || (t0_mode == TMRIF_WM_CTC);
  wire [7:0] t0_top = t0_regtop ? t0_cmpa_r : TMRIF_MAX;
  wire t0_at_top   = (t0_cnt_r == t0_top);
  wire t0_match_a  = t0_tick && (t0_cnt_r == t0_cmpa_r);
  wire t0_match_b  = t0_tick && (t0_cnt_r == t0_cmpb_r);
  wire t0_ovf_evt  = t0_tick && (t0_phase ? (t0_cnt_r == TMRIF_BOTTOM)
                   : (t0_mode == TMRIF_WM_FP_REG) ? t0_at_top
                   : (t0_cnt_r == TMRIF_MAX));

  always_comb begin
    t0_cnt_nxt  = t0_cnt_r;
    t0_down_nxt = t0_down_r;
    if (wr_t0cnt) begin
      t0_cnt_nxt = io_wdata;
    end else if (t0_tick) begin
      if (t0_phase) begin
        if (!t0_down_r && t0_at_top) begin
          t0_down_nxt = 1'b1;
          t0_cnt_nxt  = t0_cnt_r - 8'h01;
        end else if (t0_down_r && (t0_cnt_r == TMRIF_BOTTOM)) begin
          t0_down_nxt = 1'b0;
          t0_cnt_nxt  = t0_cnt_r + 8'h01;
        end else begin
          t0_cnt_nxt = t0_down_r ? t0_cnt_r - 8'h01 : t0_cnt_r + 8'h01;
        end
      end else begin
        t0_cnt_nxt = t0_at_top ? TMRIF_BOTTOM : t0_cnt_r + 8'h01;
      end
    end
  end

  // Timer1 clock selection, external pin through three-stage sampler
  wire [2:0] t1_cs    = t1_ctl_r[TMRIF_T1_CS_LSB +: 3];
  wire       t1_wide  = t1_ctl_r[TMRIF_T1_WIDE];
  wire       t1_mclr  = t1_ctl_r[TMRIF_T1_MCLR];
  wire       ext_lvl  = ext_sync_r[2];
  wire       ext_agree = (ext_sync_r[1] == ext_sync_r[2]);
  wire       ext_rise = ext_agree && ext_lvl && !ext_prev_r;
  wire       ext_fall = ext_agree && !ext_lvl && ext_prev_r;
  logic      t1_tick;
  always_comb begin
    case (t1_cs)
      3'h0:    t1_tick = 1'b0;
      3'h1:    t1_tick = 1'b1;
      3'h2:    t1_tick = t1_tick_sources[0];
      3'h3:    t1_tick = t1_tick_sources[1];
      3'h4:    t1_tick = t1_tick_sources[2];
      3'h6:    t1_tick = ext_fall;
      3'h7:    t1_tick = ext_rise;
      default: t1_tick = t1_tick_sources[2];
    endcase
  end

  // Timer1 counter unit
  wire [15:0] t1_cnt   = {t1_wide ? t1_hi_r : TMRIF_RESET8, t1_lo_r};
  wire [15:0] t1_cmp16 = {t1_cmpb_r, t1_cmpa_r};
  wire t1_top8   = t1_mclr ? (t1_lo_r == t1_cmpa_r) : (t1_lo_r == TMRIF_MAX);
  wire t1_wrap   = t1_wide ? (t1_cnt == TMRIF_MAX16) : t1_top8;
  wire [15:0] t1_inc = t1_cnt + 16'h0001;
  wire t1_go     = t1_tick && !wr_t1lo && !wr_t1hi;
  wire t1_ovf    = t1_go && (t1_wide ? (t1_cnt == TMRIF_MAX16)
                   : (t1_lo_r == TMRIF_MAX));
  wire t1_mt_a   = t1_tick && !t1_blk_r &&
                   (t1_wide ? (t1_cnt == t1_cmp16) : (t1_lo_r == t1_cmpa_r));
  wire t1_mt_b   = t1_tick && !t1_blk_r && !t1_wide && (t1_lo_r == t1_cmpb_r);

  always_comb begin
    t1_lo_nxt = t1_lo_r;
    t1_hi_nxt = t1_hi_r;
    if (wr_t1lo) begin
      t1_lo_nxt = io_wdata;
      if (t1_wide) t1_hi_nxt = t1_tmp_r;
    end else if (wr_t1hi) begin
      t1_hi_nxt = t1_hi_r; // High byte waits in the buffer until the low write
    end else if (t1_tick) begin
      if (t1_wrap) begin
        t1_lo_nxt = TMRIF_BOTTOM;
        t1_hi_nxt = TMRIF_BOTTOM;
      end else begin
        t1_lo_nxt = t1_inc[7:0];
        t1_hi_nxt = t1_wide ? t1_inc[15:8] : t1_hi_r;
      end
    end
  end

  // Flags: hardware set wins over any clear in the same cycle
  wire [7:0] set_vec = {t1_capture_evt, 1'b0, t1_mt_b, t1_mt_a, t1_ovf,
                        t0_match_b, t0_match_a, t0_ovf_evt};
  wire [7:0] clr_vec = (wr_flags ? io_wdata : 8'h00) | vector_ack;
  assign flags_nxt = ((flags_r & ~clr_vec) | set_vec) & TMRIF_RSVD_MASK;

  // Interrupt requests combine mask, flag and global enable
  wire [7:0] irq_nxt = (global_irq_en ? (mask_r & flags_r) : 8'h00)
                       & TMRIF_RSVD_MASK;

  // Compare B waveform: toggle on every compare B match, in all modes
  wire wave_b_nxt = t0_match_b ? ~wave_b_r : wave_b_r;

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (io_addr)
      TMRIF_ADDR_MASK:   rd_mux = mask_r & TMRIF_RSVD_MASK;
      TMRIF_ADDR_FLAGS:  rd_mux = flags_r & TMRIF_RSVD_MASK;
      TMRIF_ADDR_T0CMPA: rd_mux = t0_cmpa_r;
      TMRIF_ADDR_T0CMPB: rd_mux = t0_cmpb_r;
      TMRIF_ADDR_T0CNT:  rd_mux = t0_cnt_r;
      TMRIF_ADDR_T0MODE: rd_mux = {5'h00, t0_mode_r};
      TMRIF_ADDR_T1CTL:  rd_mux = t1_ctl_r;
      TMRIF_ADDR_T1CNTL: rd_mux = t1_lo_r;
      TMRIF_ADDR_T1CNTH: rd_mux = t1_wide ? t1_tmp_r : TMRIF_RESET8;
      TMRIF_ADDR_T1CMPA: rd_mux = t1_cmpa_r;
      TMRIF_ADDR_T1CMPB: rd_mux = t1_cmpb_r;
      default:           rd_mux = TMRIF_RESET8;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r     <= TMRIF_RESET8;
      flags_r    <= TMRIF_RESET8;
      t0_cmpa_r  <= TMRIF_RESET8;
      t0_cmpb_r  <= TMRIF_RESET8;
      t0_cnt_r   <= TMRIF_RESET8;
      t0_mode_r  <= TMRIF_WM_NORMAL;
      t0_down_r  <= 1'b0;
      wave_b_r   <= 1'b0;
      irq_req    <= TMRIF_RESET8;
      io_rdata   <= TMRIF_RESET8;
      t0_wave_out_b <= 1'b0;
    end else begin
      if (wr_mask) mask_r <= io_wdata & TMRIF_RSVD_MASK;
      flags_r    <= flags_nxt;
      if (wr_t0cmpa) t0_cmpa_r <= io_wdata;
      if (wr_t0cmpb) t0_cmpb_r <= io_wdata;
      if (wr_t0mode) t0_mode_r <= io_wdata[2:0];
      t0_cnt_r   <= t0_cnt_nxt;
      t0_down_r  <= t0_down_nxt;
      wave_b_r   <= wave_b_nxt;
      t0_wave_out_b <= wave_b_nxt;
      irq_req    <= irq_nxt;
      io_rdata   <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      t1_ctl_r   <= TMRIF_RESET8;
      t1_cmpa_r  <= TMRIF_RESET8;
      t1_cmpb_r  <= TMRIF_RESET8;
      t1_lo_r    <= TMRIF_RESET8;
      t1_hi_r    <= TMRIF_RESET8;
      t1_tmp_r   <= TMRIF_RESET8;
      t1_blk_r   <= 1'b0;
      ext_sync_r <= 3'h0;
      ext_prev_r <= 1'b0;
    end else begin
      if (wr_t1ctl)  t1_ctl_r  <= io_wdata;
      if (wr_t1cmpa) t1_cmpa_r <= io_wdata;
      if (wr_t1cmpb) t1_cmpb_r <= io_wdata;
      t1_lo_r    <= t1_lo_nxt;
      t1_hi_r    <= t1_hi_nxt;
      // Temp buffer: filled by high write or snapshot on low read
      if (wr_t1hi)       t1_tmp_r <= io_wdata;
      else if (rd_t1lo)  t1_tmp_r <= t1_hi_r;
      // Count write masks compare matches until the next tick
      if (wr_t1lo || wr_t1hi) t1_blk_r <= 1'b1;
      else if (t1_tick)       t1_blk_r <= 1'b0;
      ext_sync_r <= {ext_sync_r[1:0], t1_ext_pin};
      if (ext_agree) ext_prev_r <= ext_lvl;
    end
  end

  // Assertions
  reset_mask_a: assert property (@(posedge sys_clk) $rose(arst_n) |-> mask_r == 8'h00)
    else $error("mask not zero after reset");
  rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    io_rd && (io_addr == TMRIF_ADDR_MASK || io_addr == TMRIF_ADDR_FLAGS)
    |=> !io_rdata[TMRIF_B_RSVD])
    else $error("reserved bit read nonzero");
  irq_cmpb_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    irq_req[TMRIF_B_T0_CMPB] |-> $past(global_irq_en && mask_r[TMRIF_B_T0_CMPB]
    && flags_r[TMRIF_B_T0_CMPB]))
    else $error("compare B request without cause");
  irq_cmpa_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(global_irq_en && mask_r[TMRIF_B_T0_CMPA] && flags_r[TMRIF_B_T0_CMPA])
    |-> irq_req[TMRIF_B_T0_CMPA])
    else $error("compare A request missing");
  irq_ovf_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !global_irq_en ##1 1'b1 |-> !irq_req[TMRIF_B_T0_OVF])
    else $error("overflow request while globally disabled");
  flag_setwin_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t0_match_b |=> flags_r[TMRIF_B_T0_CMPB])
    else $error("compare B flag not set");
  flag_clr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    vector_ack[TMRIF_B_T0_CMPA] && !t0_match_a |=> !flags_r[TMRIF_B_T0_CMPA])
    else $error("compare A flag not cleared");
  t1_stop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_cs == TMRIF_CS_STOP && !wr_t1lo && !wr_t1hi |=> $stable(t1_lo_r))
    else $error("timer1 counted while stopped");
  t1_wrprio_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_t1lo |=> t1_lo_r == $past(io_wdata))
    else $error("count write lost");
  t1_ovf_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_ovf && !t1_wide |=> t1_lo_r == 8'h00 && flags_r[TMRIF_B_T1_OVF])
    else $error("timer1 overflow flag timing");

  // Timer0 waveform output and overflow flag
  wave_toggle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t0_match_b |=> t0_wave_out_b != $past(t0_wave_out_b))
    else $error("compare B output did not toggle");
  ovf_setwin_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t0_ovf_evt |=> flags_r[TMRIF_B_T0_OVF])
    else $error("overflow flag not set");
  ovf_wrclr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_flags && io_wdata[TMRIF_B_T0_OVF] && !t0_ovf_evt |=> !flags_r[TMRIF_B_T0_OVF])
    else $error("overflow flag not cleared by write");
  phase_ovf_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t0_tick && t0_phase && (t0_cnt_r == TMRIF_BOTTOM) |=> flags_r[TMRIF_B_T0_OVF])
    else $error("phase correct overflow missed at bottom");

  // Register bus, interrupt gating and capture flag
  mask_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_mask |=> mask_r == ($past(io_wdata) & TMRIF_RSVD_MASK))
    else $error("mask write not stored");
  glob_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !global_irq_en |=> irq_req == TMRIF_RESET8)
    else $error("request while globally disabled");
  capt_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_capture_evt |=> flags_r[TMRIF_B_T1_CAPT])
    else $error("capture flag not set");

  // Timer1 clock selection
  stop_tick_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_cs == TMRIF_CS_STOP |-> !t1_tick)
    else $error("tick while clock stopped");
  ext_once_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ext_rise |=> !ext_rise)
    else $error("pin edge counted twice");

  // Timer1 counter and compare units
  wide_cmpb_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_wide |-> !t1_mt_b)
    else $error("second compare unit active in wide mode");
  wrap16_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    t1_go && t1_wide && (t1_cnt == TMRIF_MAX16) |=> t1_lo_r == TMRIF_BOTTOM && t1_hi_r == TMRIF_BOTTOM)
    else $error("wide counter did not wrap");
  cnt_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    io_rd && (io_addr == TMRIF_ADDR_T1CNTL) |=> io_rdata == $past(t1_lo_r))
    else $error("count read wrong");

  // Wide access through the temporary byte
  hi_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wr_t1lo && t1_wide |=> t1_hi_r == $past(t1_tmp_r))
    else $error("high byte not loaded from buffer");
  hi_snap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd_t1lo && !wr_t1hi |=> t1_tmp_r == $past(t1_hi_r))
    else $error("high byte not snapshotted");

endmodule : tmrif_core

// ===== dv/tmrif_cpu_model.sv
// CPU core model issuing I/O register reads and writes
module tmrif_cpu_model
  import tmrif_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // I/O register bus
  output logic      [5:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    io_addr  = 6'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    io_wr    = 1'b0;
    // Stale data would hide a late capture, so scramble it
    io_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    d     = io_rdata;
    io_rd = 1'b0;
  endtask : rd

  task automatic wr16(input logic [15:0] v);
    wr(TMRIF_ADDR_T1CNTH, v[15:8]);
    wr(TMRIF_ADDR_T1CNTL, v[7:0]);
  endtask : wr16

  task automatic rd16(output logic [15:0] v);
    rd(TMRIF_ADDR_T1CNTL, v[7:0]);
    rd(TMRIF_ADDR_T1CNTH, v[15:8]);
  endtask : rd16
endmodule : tmrif_cpu_model

// ===== dv/tb_timer_irq_flags_and_counter1.sv
// Self-checking bench for the timer flag registers and Timer1 counter
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_timer_irq_flags_and_counter1;
  timeunit 1ns;
  timeprecision 100ps;
  import tmrif_pkg::*;
  logic        t1_ext_pin, wave_b;
  logic        sys_clk, arst_n, io_wr, io_rd, global_irq_en, t0_tick, t1_capture_evt;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, vector_ack, irq_req, rdv;
  logic [2:0]  t1_tick_sources;
  logic [15:0] v16;
  int          mismatches, n_tests, cycles, t0c, t1c, flg, msk, cs, rv;
  bit          wide, mclr, wb;

  tmrif_core DUT (.sys_clk(sys_clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_en(global_irq_en),
    .vector_ack(vector_ack), .irq_req(irq_req), .t0_tick(t0_tick), .t0_wave_out_b(wave_b),
    .t1_tick_sources(t1_tick_sources), .t1_ext_pin(t1_ext_pin),
    .t1_capture_evt(t1_capture_evt));
  tmrif_cpu_model cpu (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  always #12.5 sys_clk = ~sys_clk;
  // Whole run needs about 700 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic t0_ticks(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 t0_tick = 1'b1;
      @(posedge sys_clk);
      #1 t0_tick = 1'b0;
      if (t0c == 8'h40) flg |= 4;
      if (t0c == 8'h80) flg |= 2;
      wb ^= (t0c == 8'h40);
      t0c = (t0c + 1) % 256;
      if (t0c == 0) flg |= 1;
    end
  endtask : t0_ticks

  task automatic t1_tick();
    @(posedge sys_clk);
    #1 t1_tick_sources = 3'h1;
    @(posedge sys_clk);
    #1 t1_tick_sources = 3'h0;
    if (cs != 0) begin
      if (mclr && !wide && t1c == 5) t1c = 0;
      else t1c = (t1c + 1) % (wide ? 65536 : 256);
      if (t1c == 0 && !(mclr && !wide)) flg |= 8;
    end
  endtask : t1_tick

  // Pin pulse long enough to pass the three-stage sampler
  task automatic ext_pulse();
    @(posedge sys_clk);
    #1 t1_ext_pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 t1_ext_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    t1c = (t1c + 1) % 65536;
  endtask : ext_pulse

  task automatic chk_reg(string nm, logic [5:0] a, int e, logic [7:0] m);
    cpu.rd(a, rdv);
    `CHK(nm, 8'(e) & m, rdv & m)
  endtask : chk_reg

  task automatic chk_irq();
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("irq_req", 8'(msk & flg & (global_irq_en ? 255 : 0)) & 8'h47, irq_req & 8'h47)
  endtask : chk_irq

  task automatic done(string nm);
    $display("finished %s", nm);
  endtask : done

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  initial begin
    {sys_clk, arst_n, global_irq_en, t0_tick, t1_capture_evt, wide, mclr} = '0;
    {t1_ext_pin, wb} = '0;
    {vector_ack, t1_tick_sources, cycles, mismatches, n_tests, t0c, t1c, flg, msk, cs} = '0;
    rv = $urandom(49);
    repeat (16) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk_reg("mask reset", TMRIF_ADDR_MASK, 0, 8'hff);
    cpu.wr(TMRIF_ADDR_MASK, 8'hff);
    chk_reg("mask bit6", TMRIF_ADDR_MASK, 8'hbf, 8'hff);
    done("registers");
    cpu.wr(TMRIF_ADDR_T0CMPA, 8'h80);
    cpu.wr(TMRIF_ADDR_T0CMPB, 8'h40);
    cpu.wr(TMRIF_ADDR_MASK, 8'h07);
    msk = 7;
    cpu.wr(TMRIF_ADDR_FLAGS, 8'hff);
    t0_ticks(8'h42);
    chk_reg("t0 cmp b flag", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    global_irq_en = 1'b1;
    chk_irq();
    global_irq_en = 1'b0;
    chk_irq();
    @(posedge sys_clk);
    #1 vector_ack = 8'h04;
    @(posedge sys_clk);
    #1 vector_ack = 8'h00;
    flg &= ~4;
    chk_reg("vector clear", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    t0_ticks(8'h40);
    chk_reg("t0 cmp a flag", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    global_irq_en = 1'b1;
    chk_irq();
    cpu.wr(TMRIF_ADDR_FLAGS, 8'h02);
    flg &= ~2;
    chk_reg("write one clear", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    t0_ticks(8'h7e);
    chk_reg("t0 overflow", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    chk_irq();
    chk_reg("t0 count", TMRIF_ADDR_T0CNT, t0c, 8'hff);
    `CHK("wave b", wb, wave_b)
    cpu.wr(TMRIF_ADDR_T0MODE, 8'h01);
    cpu.wr(TMRIF_ADDR_FLAGS, 8'hff);
    flg = 0;
    t0_ticks(1);
    flg |= 1;
    chk_reg("t0 phase bottom", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    cpu.wr(TMRIF_ADDR_T0MODE, 8'h00);
    done("timer0");
    rv = $urandom_range(255);
    cpu.wr(TMRIF_ADDR_T1CNTL, 8'(rv));
    t1c = rv;
    repeat ($urandom_range(3, 1)) t1_tick();
    chk_reg("t1 stopped", TMRIF_ADDR_T1CNTL, t1c, 8'hff);
    cpu.wr(TMRIF_ADDR_T1CTL, 8'h02);
    cs = 2;
    cpu.wr(TMRIF_ADDR_T1CNTL, 8'hfd);
    t1c = 8'hfd;
    cpu.wr(TMRIF_ADDR_FLAGS, 8'hff);
    flg = 0;
    repeat (3) t1_tick();
    chk_reg("t1 wrap", TMRIF_ADDR_T1CNTL, t1c, 8'hff);
    chk_reg("t1 overflow", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    fork
      cpu.wr(TMRIF_ADDR_T1CNTL, 8'h33);
      t1_tick();
    join
    t1c = 8'h33;
    chk_reg("write priority", TMRIF_ADDR_T1CNTL, t1c, 8'hff);
    cpu.wr(TMRIF_ADDR_T1CMPA, 8'h05);
    cpu.wr(TMRIF_ADDR_T1CTL, 8'h0a);
    mclr = 1'b1;
    cpu.wr(TMRIF_ADDR_T1CNTL, 8'h00);
    t1c = 0;
    repeat (8) t1_tick();
    chk_reg("match clear", TMRIF_ADDR_T1CNTL, t1c, 8'hff);
    done("timer1 8-bit");
    cpu.wr(TMRIF_ADDR_T1CTL, 8'h12);
    {wide, mclr} = 2'b10;
    cpu.wr16(16'h12ff);
    t1c = 16'h12ff;
    t1_tick();
    cpu.rd16(v16);
    `CHK("t1 16-bit", 16'(t1c), v16)
    cpu.wr(TMRIF_ADDR_FLAGS, 8'h08);
    flg &= ~8;
    cpu.wr16(16'hffff);
    t1c = 16'hffff;
    t1_tick();
    chk_reg("t1 16 overflow", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    @(posedge sys_clk);
    #1 t1_capture_evt = 1'b1;
    @(posedge sys_clk);
    #1 t1_capture_evt = 1'b0;
    flg |= 8'h80;
    chk_reg("capture flag", TMRIF_ADDR_FLAGS, flg, 8'hcf);
    cpu.wr(TMRIF_ADDR_T1CTL, 8'h17);
    cs = 7;
    cpu.wr16(16'h0010);
    t1c = 16'h0010;
    repeat (3) ext_pulse();
    cpu.rd16(v16);
    `CHK("t1 pin clock", 16'(t1c), v16)
    done("timer1 16-bit");
    @(posedge sys_clk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk_reg("mask rerun", TMRIF_ADDR_MASK, 0, 8'hff);
    chk_reg("t1 count rerun", TMRIF_ADDR_T1CNTL, 0, 8'hff);
    done("reset");
    summarize();
  end
endmodule : tb_timer_irq_flags_and_counter1
